// file: core/epv_pkg.sv
package epv_pkg;

    // Widths of vector numbers and vector addresses
    localparam int VEC_W = 7;
    localparam int ADDR_W = 24;

    typedef logic [VEC_W-1:0] epv_vec_t;
    typedef logic [ADDR_W-1:0] epv_addr_t;

    // Each vector table entry is four bytes
    localparam int VEC_ENTRY_SHIFT = 2;

    // Fixed vector numbers
    localparam epv_vec_t VEC_RESET = 7'h00;
    localparam epv_vec_t VEC_DIRECT = 7'h06;
    localparam epv_vec_t VEC_NMI = 7'h07;
    localparam epv_vec_t VEC_TRAP_BASE = 7'h08;
    localparam epv_vec_t VEC_IRQ_LOW_BASE = 7'h10;
    localparam epv_vec_t VEC_IRQ6 = 7'h16;
    localparam epv_vec_t VEC_IRQ7 = 7'h17;
    localparam epv_vec_t VEC_KEY_LOW_EXT = 7'h1E;
    localparam epv_vec_t VEC_KEY_HIGH_EXT = 7'h1F;
    localparam epv_vec_t VEC_WAKEUP = 7'h21;
    localparam epv_vec_t VEC_IRQ_HIGH_BASE = 7'h38;

    // On-chip peripheral vector ranges
    localparam epv_vec_t VEC_INT_A_LO = 7'h18;
    localparam epv_vec_t VEC_INT_A_HI = 7'h1D;
    localparam epv_vec_t VEC_INT_B_LO = 7'h22;
    localparam epv_vec_t VEC_INT_B_HI = 7'h37;
    localparam epv_vec_t VEC_INT_C_LO = 7'h40;
    localparam epv_vec_t VEC_INT_C_HI = 7'h7F;

    // External interrupt input numbers that split the vector map
    localparam epv_vec_t IRQ_LOW_LAST = 7'h05;
    localparam epv_vec_t IRQ_SIX = 7'h06;
    localparam epv_vec_t IRQ_SEVEN = 7'h07;
    localparam epv_vec_t IRQ_HIGH_FIRST = 7'h08;
    localparam epv_vec_t IRQ_LAST = 7'h0F;

    // Interrupt source classes from the interrupt controller
    typedef enum logic [2:0] {
        EPV_SRC_NMI,
        EPV_SRC_IRQ,
        EPV_SRC_KEY_LOW,
        EPV_SRC_KEY_HIGH,
        EPV_SRC_WAKEUP,
        EPV_SRC_INTERNAL
    } epv_src_t;

    // Exception classes
    typedef enum logic [1:0] {
        EPV_EXC_RESET,
        EPV_EXC_INTERRUPT,
        EPV_EXC_DIRECT,
        EPV_EXC_TRAP
    } epv_exc_kind_t;

    // Pending interrupt from the interrupt controller
    typedef struct packed {
        logic valid;
        epv_src_t src;
        epv_vec_t index;
    } epv_int_req_t;

    // Instruction boundary from the sequencer
    typedef struct packed {
        logic valid;
        logic ccr_instr;
    } epv_boundary_t;

    // Trap instruction request with its vector index
    typedef struct packed {
        logic valid;
        logic [1:0] index;
    } epv_trap_req_t;

    // Exception command to the sequencer
    typedef struct packed {
        logic valid;
        epv_exc_kind_t kind;
        logic save_context;
        epv_vec_t vector;
        epv_addr_t address;
    } epv_exc_cmd_t;

    // Result of mapping an interrupt source to a vector
    typedef struct packed {
        logic ok;
        epv_vec_t vec;
    } epv_vec_pick_t;

endpackage

// file: core/epv_sync2.sv
`timescale 1ns/1ps

// Two-stage synchroniser for a level from outside the clock domain
module epv_sync2 #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);

    logic stage_one;
    logic next_stage_one;
    logic next_sync_out;

    // Shift the level through both stages
    always_comb begin
        next_stage_one = async_in;
        next_sync_out = stage_one;
    end

    // Register both stages
    always_ff @(posedge clock) begin
        if (reset) begin
            stage_one <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage_one <= next_stage_one;
            sync_out <= next_sync_out;
        end
    end

endmodule

// file: core/epv_exception_unit.sv
`timescale 1ns/1ps

// Behaviour
// - Simultaneous exceptions ranked: reset, interrupt, direct transition, trap.
// - Reset handling starts on reset pin rising edge or watchdog overflow.
// - Interrupts start only at instruction or exception end with request pending.
// - No interrupt detection after condition code logic/load instructions or reset handling.
// - Direct transition handling starts when sleep causes direct transition.
// - Trap requests accepted unmasked any time in program execution.
// - Every source has own vector number, except 22 and 23 shared in compatible mode; entry address is four times it.
// - Vector mode select bit picks compatible or extended vector table.
// - Four trap sources use vectors 8 to 11 in both modes.
// - External inputs 0-5 use 16-21, inputs 8-15 use 56-63.
// - Compatible mode: vector 22 and 23 shared with key input groups.
// - Extended mode: key groups get vectors 30 and 31.
// - Wake-up inputs 15..8 use vector 33 in both modes.
// - Peripheral interrupts use vectors 24-29, 34-55 and 64-127.
// - Reserved vectors 1-5, 12-15, 32 never produced; 30, 31 in compatible.
// - Reset pin low halts all processing and holds reset state.
// - Reset returns processor and peripheral registers to initial values.
// - After reset initialisation, reset vector fetched into program counter.
// - All interrupts, even non-maskable, blocked until first instruction executes.
// - Trap index 0 to 3 selects one of four trap vectors.
// - Interrupt or trap pushes program counter and condition code register first.
module epv_exception_unit (
    input wire logic clock,
    input wire logic reset,
    input wire logic external_reset_input_n,
    input wire logic watchdog_overflow,
    input wire logic vector_mode_select,
    input wire epv_pkg::epv_boundary_t boundary,
    input wire epv_pkg::epv_int_req_t int_req,
    input wire logic sleep_direct,
    input wire epv_pkg::epv_trap_req_t trap_req,
    input wire logic exc_done,
    output logic cpu_halt,
    output logic periph_init,
    output logic ints_blocked,
    output epv_pkg::epv_exc_cmd_t exc,
    output logic int_ack,
    output logic direct_ack,
    output logic trap_ack
);

    // Unit sequencing states
    typedef enum logic [2:0] {
        ST_HALT,
        ST_INIT,
        ST_RESET_FETCH,
        ST_FIRST,
        ST_RUN,
        ST_SERVICE,
        ST_FIRST_SERVICE
    } epv_state_t;

    epv_state_t state;
    epv_state_t next_state;
    epv_pkg::epv_exc_cmd_t next_exc;
    logic next_cpu_halt;
    logic next_periph_init;
    logic next_ints_blocked;
    logic next_int_ack;
    logic next_direct_ack;
    logic next_trap_ack;
    logic pin_high;
    epv_pkg::epv_vec_pick_t pick;
    logic int_seen;
    logic int_boundary;
    logic first_window;
    epv_pkg::epv_vec_t trap_vec;

    // Build one exception command with its entry address
    function automatic epv_pkg::epv_exc_cmd_t make_cmd(
        input epv_pkg::epv_exc_kind_t kind,
        input epv_pkg::epv_vec_t vec,
        input logic save
    );
        epv_pkg::epv_exc_cmd_t cmd;
        cmd.valid = 1'b1;
        cmd.kind = kind;
        cmd.save_context = save;
        cmd.vector = vec;
        cmd.address = epv_pkg::epv_addr_t'(vec) << epv_pkg::VEC_ENTRY_SHIFT;
        return cmd;
    endfunction

    // Map an interrupt source to its vector number in the current mode
    function automatic epv_pkg::epv_vec_pick_t map_interrupt(
        input epv_pkg::epv_int_req_t req,
        input logic extended
    );
        epv_pkg::epv_vec_pick_t p;
        p.ok = 1'b1;
        p.vec = epv_pkg::VEC_NMI;
        case (req.src)
            epv_pkg::EPV_SRC_NMI: begin
                p.vec = epv_pkg::VEC_NMI;
            end
            epv_pkg::EPV_SRC_IRQ: begin
                if (req.index <= epv_pkg::IRQ_LOW_LAST) begin
                    p.vec = epv_pkg::VEC_IRQ_LOW_BASE + req.index;
                end else if (req.index == epv_pkg::IRQ_SIX) begin
                    p.vec = epv_pkg::VEC_IRQ6;
                end else if (req.index == epv_pkg::IRQ_SEVEN) begin
                    p.vec = epv_pkg::VEC_IRQ7;
                end else if (req.index <= epv_pkg::IRQ_LAST) begin
                    p.vec = epv_pkg::VEC_IRQ_HIGH_BASE + (req.index - epv_pkg::IRQ_HIGH_FIRST);
                end else begin
                    p.ok = 1'b0;
                end
            end
            epv_pkg::EPV_SRC_KEY_LOW: begin
                p.vec = extended ? epv_pkg::VEC_KEY_LOW_EXT : epv_pkg::VEC_IRQ6;
            end
            epv_pkg::EPV_SRC_KEY_HIGH: begin
                p.vec = extended ? epv_pkg::VEC_KEY_HIGH_EXT : epv_pkg::VEC_IRQ7;
            end
            epv_pkg::EPV_SRC_WAKEUP: begin
                p.vec = epv_pkg::VEC_WAKEUP;
            end
            epv_pkg::EPV_SRC_INTERNAL: begin
                p.vec = req.index;
                p.ok = ((req.index >= epv_pkg::VEC_INT_A_LO) && (req.index <= epv_pkg::VEC_INT_A_HI))
                    || ((req.index >= epv_pkg::VEC_INT_B_LO) && (req.index <= epv_pkg::VEC_INT_B_HI))
                    || ((req.index >= epv_pkg::VEC_INT_C_LO) && (req.index <= epv_pkg::VEC_INT_C_HI));
            end
            default: begin
                p.ok = 1'b0;
            end
        endcase
        return p;
    endfunction

    // pin low time kept outside, no filter
    epv_sync2 #(
        .RESET_VALUE(1'b0)
    ) u_reset_pin_sync (
        .clock(clock),
        .reset(reset),
        .async_in(external_reset_input_n),
        .sync_out(pin_high)
    );

    // Vector lookup for the pending interrupt
    always_comb begin
        pick = map_interrupt(int_req, vector_mode_select);
        int_seen = int_req.valid && pick.ok;
    end

    always_comb begin
        int_boundary = boundary.valid && !boundary.ccr_instr;
    end

    // First-instruction window, where only trap and direct run
    always_comb begin
        first_window = (state == epv_state_t'(ST_FIRST));
    end

    // trap index picks one of four vectors
    always_comb begin
        trap_vec = epv_pkg::VEC_TRAP_BASE + epv_pkg::epv_vec_t'(trap_req.index);
    end

    // Next state, exception command and handshake pulses
    always_comb begin
        next_state = state;
        next_exc = exc;
        next_int_ack = 1'b0;
        next_direct_ack = 1'b0;
        next_trap_ack = 1'b0;
        if (!pin_high) begin
            next_state = ST_HALT;
            next_exc = '0;
        end else if (watchdog_overflow) begin
            next_state = ST_INIT;
            next_exc = '0;
        end else begin
            case (state)
                ST_HALT: begin
                    next_state = ST_INIT;
                end
                ST_INIT: begin
                    next_exc = make_cmd(epv_pkg::EPV_EXC_RESET, epv_pkg::VEC_RESET, 1'b0);
                    next_state = ST_RESET_FETCH;
                end
                ST_RESET_FETCH: begin
                    if (exc_done) begin
                        next_exc = '0;
                        next_state = ST_FIRST;
                    end
                end
                ST_FIRST, ST_RUN: begin
                    if ((state == ST_RUN) && int_boundary && int_seen) begin
                        next_exc = make_cmd(epv_pkg::EPV_EXC_INTERRUPT, pick.vec, 1'b1);
                        next_int_ack = 1'b1;
                        next_state = ST_SERVICE;
                    end else if (sleep_direct) begin
                        next_exc = make_cmd(epv_pkg::EPV_EXC_DIRECT, epv_pkg::VEC_DIRECT, 1'b1);
                        next_direct_ack = 1'b1;
                        next_state = first_window ? ST_FIRST_SERVICE : ST_SERVICE;
                    end else if (trap_req.valid) begin
                        next_exc = make_cmd(epv_pkg::EPV_EXC_TRAP, trap_vec, 1'b1);
                        next_trap_ack = 1'b1;
                        next_state = first_window ? ST_FIRST_SERVICE : ST_SERVICE;
                    end else if (first_window && boundary.valid) begin
                        next_state = ST_RUN;
                    end
                end
                ST_SERVICE: begin
                    if (exc_done) begin
                        if (int_seen) begin
                            next_exc = make_cmd(epv_pkg::EPV_EXC_INTERRUPT, pick.vec, 1'b1);
                            next_int_ack = 1'b1;
                        end else begin
                            next_exc = '0;
                            next_state = ST_RUN;
                        end
                    end
                end
                ST_FIRST_SERVICE: begin
                    if (exc_done) begin
                        // back to first window, still blocked
                        next_exc = '0;
                        next_state = ST_FIRST;
                    end
                end
                default: begin
                    next_state = ST_HALT;
                    next_exc = '0;
                end
            endcase
        end
    end

    // Status levels derived from the coming state
    always_comb begin
        // Core held while the pin is low or during initialisation
        next_cpu_halt = (next_state == ST_HALT) || (next_state == ST_INIT);
        next_periph_init = (next_state == ST_INIT);
        // block all interrupts until first instruction ends
        next_ints_blocked = (next_state == ST_HALT) || (next_state == ST_INIT)
            || (next_state == ST_RESET_FETCH) || (next_state == ST_FIRST)
            || (next_state == ST_FIRST_SERVICE);
    end

    // Register state, command and handshake pulses
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= ST_HALT;
            exc <= '0;
            int_ack <= 1'b0;
            direct_ack <= 1'b0;
            trap_ack <= 1'b0;
        end else begin
            state <= next_state;
            exc <= next_exc;
            int_ack <= next_int_ack;
            direct_ack <= next_direct_ack;
            trap_ack <= next_trap_ack;
        end
    end

    // Register the status levels
    always_ff @(posedge clock) begin
        if (reset) begin
            // Reset leaves the core halted and blocked
            cpu_halt <= 1'b1;
            periph_init <= 1'b0;
            ints_blocked <= 1'b1;
        end else begin
            cpu_halt <= next_cpu_halt;
            periph_init <= next_periph_init;
            ints_blocked <= next_ints_blocked;
        end
    end

endmodule

// file: bench/epv_exc_chk.sv
`timescale 1ns/1ps

// Port-level checks of the exception unit
module epv_exc_chk (
    input wire logic clock,
    input wire logic reset,
    input wire logic external_reset_input_n,
    input wire logic watchdog_overflow,
    input wire logic vector_mode_select,
    input wire epv_pkg::epv_boundary_t boundary,
    input wire epv_pkg::epv_int_req_t int_req,
    input wire logic sleep_direct,
    input wire epv_pkg::epv_trap_req_t trap_req,
    input wire logic exc_done,
    input wire logic cpu_halt,
    input wire logic periph_init,
    input wire logic ints_blocked,
    input wire epv_pkg::epv_exc_cmd_t exc,
    input wire logic int_ack,
    input wire logic direct_ack,
    input wire logic trap_ack
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_ADDR: assert property (exc.valid |-> exc.address == {15'h0000, exc.vector, 2'h0})
        else $error("vector address wrong");
    AST_RSTVEC: assert property (periph_init |=> !periph_init && exc.valid
        && exc.kind == 2'h0 && exc.vector == 7'h00) else $error("reset fetch missing");
    AST_HALT: assert property (!external_reset_input_n [*3] |=> cpu_halt && !exc.valid)
        else $error("pin low without halt");
    AST_WDOG: assert property (external_reset_input_n [*3] ##0
        (watchdog_overflow && !cpu_halt) |=> periph_init) else $error("overflow ignored");
    AST_BLOCK: assert property (ints_blocked |=> !int_ack)
        else $error("interrupt taken while blocked");
    AST_CCOP: assert property (boundary.valid && boundary.ccr_instr && !exc_done |=> !int_ack)
        else $error("interrupt after condition code instruction");
    AST_PRIO: assert property (boundary.valid && !boundary.ccr_instr && int_req.valid
        && int_req.src == 3'h0 && !ints_blocked && !exc.valid && !cpu_halt
        && !watchdog_overflow && external_reset_input_n |=> int_ack && !direct_ack && !trap_ack)
        else $error("pending interrupt not first");
    AST_TRAP: assert property (trap_ack |-> exc.kind == 2'h3
        && exc.vector == {5'h02, $past(trap_req.index)}) else $error("trap vector wrong");
    AST_RSV: assert property (exc.valid |-> !(exc.vector inside {[7'h01:7'h05], [7'h0C:7'h0F], 7'h20}))
        else $error("reserved vector issued");
    AST_KEYEXT: assert property (int_ack && $past(int_req.src) == 3'h2
        |-> exc.vector == ($past(vector_mode_select) ? 7'h1E : 7'h16)) else $error("key vector");

    // Main scenarios
    CVR_EXT: cover property (int_ack && vector_mode_select);
    CVR_TRAP: cover property (trap_ack);
    CVR_DIR: cover property (direct_ack);
endmodule

bind epv_exception_unit epv_exc_chk u_chk (.clock(clock), .reset(reset),
    .external_reset_input_n(external_reset_input_n), .watchdog_overflow(watchdog_overflow),
    .vector_mode_select(vector_mode_select), .boundary(boundary), .int_req(int_req),
    .sleep_direct(sleep_direct), .trap_req(trap_req), .exc_done(exc_done),
    .cpu_halt(cpu_halt), .periph_init(periph_init), .ints_blocked(ints_blocked),
    .exc(exc), .int_ack(int_ack), .direct_ack(direct_ack), .trap_ack(trap_ack));

// file: bench/epv_seq_model.sv
`timescale 1ns/1ps

// Sequencer and interrupt controller stand-in
module epv_seq_model (
    input wire logic clock,
    input wire epv_pkg::epv_exc_cmd_t exc,
    input wire logic int_ack,
    input wire logic direct_ack,
    input wire logic trap_ack,
    input wire logic [3:0] lat,
    output epv_pkg::epv_int_req_t int_req,
    output logic sleep_direct,
    output epv_pkg::epv_trap_req_t trap_req,
    output logic exc_done
);
    logic [3:0] cnt;
    initial begin
        int_req = '0;
        sleep_direct = 1'b0;
        trap_req = '0;
        exc_done = 1'b0;
        cnt = 4'h0;
    end
    // Drop requests on ack, scramble stale index, finish after lat cycles
    always @(negedge clock) begin
        exc_done <= 1'b0;
        if (int_ack) int_req <= '{1'b0, int_req.src, ~int_req.index};
        if (direct_ack) sleep_direct <= 1'b0;
        if (trap_ack) trap_req <= '{1'b0, ~trap_req.index};
        cnt <= 4'h0;
        if (exc.valid && !exc_done) begin
            cnt <= cnt + 4'h1;
            if (cnt >= lat) exc_done <= 1'b1;
        end
    end
    task automatic post_int(input logic [2:0] s, input logic [6:0] i);
        int_req = '{1'b1, epv_pkg::epv_src_t'(s), i};
    endtask
    task automatic post_trap(input logic [1:0] i);
        trap_req = '{1'b1, i};
    endtask
    task automatic post_dir();
        sleep_direct = 1'b1;
    endtask
    task automatic clr();
        int_req.valid = 1'b0;
    endtask
endmodule

// file: bench/tb.sv
`timescale 1ns/1ps

// Self-checking bench for the exception unit
module tb;
    logic clock, reset, pin_n, wdog, vms, exc_done, cpu_halt, periph_init;
    logic ints_blocked, int_ack, direct_ack, trap_ack, sleep_direct;
    logic [3:0] lat;
    logic [2:0] acks;
    epv_pkg::epv_boundary_t boundary;
    epv_pkg::epv_int_req_t int_req;
    epv_pkg::epv_trap_req_t trap_req;
    epv_pkg::epv_exc_cmd_t exc, got;
    int failures, checked;

    epv_exception_unit dut (.clock(clock), .reset(reset), .external_reset_input_n(pin_n),
        .watchdog_overflow(wdog), .vector_mode_select(vms), .boundary(boundary),
        .int_req(int_req), .sleep_direct(sleep_direct), .trap_req(trap_req),
        .exc_done(exc_done), .cpu_halt(cpu_halt), .periph_init(periph_init),
        .ints_blocked(ints_blocked), .exc(exc), .int_ack(int_ack),
        .direct_ack(direct_ack), .trap_ack(trap_ack));
    epv_seq_model u_seq (.clock(clock), .exc(exc), .int_ack(int_ack), .direct_ack(direct_ack),
        .trap_ack(trap_ack), .lat(lat), .int_req(int_req), .sleep_direct(sleep_direct),
        .trap_req(trap_req), .exc_done(exc_done));

    // Clock at 40 MHz
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Wait for an acknowledge; boundary lasts one cycle
    task automatic grab(input int n);
        acks = 3'h0;
        for (int k = 0; k < n && acks == 3'h0; k++) begin
            @(negedge clock);
            boundary = '0;
            acks = {int_ack, direct_ack, trap_ack};
            got = exc;
        end
    endtask

    task automatic idle();
        for (int k = 0; k < 30 && exc.valid !== 1'b0; k++) @(negedge clock);
        cyc(1);
    endtask

    // Release the pin and follow the reset fetch
    task automatic rise();
        pin_n = 1'b1;
        cyc(2);
        chk("init early", periph_init, 1'b0);
        cyc(1);
        chk("init", {periph_init, cpu_halt}, 2'h3);
        cyc(1);
        chk("fetch", {exc.valid, exc.kind, exc.vector, cpu_halt}, {1'b1, 2'h0, 7'h00, 1'b0});
        chk("fetch addr", exc.address, 24'h000000);
        idle();
        chk("blocked", ints_blocked, 1'b1);
    endtask

    task automatic t_reset();
        reset = 1'b1;
        cyc(4);
        reset = 1'b0;
        // power-on hold, shortened for run time
        cyc(20);
        chk("held", cpu_halt, 1'b1);
        rise();
    endtask

    task automatic t_block();
        u_seq.post_int(3'h0, 7'h00);
        boundary = '{1'b1, 1'b0};
        grab(4);
        chk("blocked int", {acks, ints_blocked}, 4'h0);
        boundary = '{1'b1, 1'b0};
        grab(4);
        chk("nmi", {acks, got.vector}, {3'h4, 7'h07});
        idle();
    endtask

    task automatic map1(input logic m, input logic [2:0] s, input logic [6:0] i, input logic [6:0] v);
        vms = m;
        u_seq.post_int(s, i);
        grab(3);
        chk("no boundary", acks, 3'h0);
        boundary = '{1'b1, 1'b1};
        grab(3);
        chk("cc op boundary", acks, 3'h0);
        boundary = '{1'b1, 1'b0};
        grab(4);
        chk("int ack", acks, (v == 7'h00) ? 3'h0 : 3'h4);
        if (v != 7'h00) begin
            chk("int vec", got.vector, v);
            chk("int addr", got.address, {15'h0000, v, 2'h0});
            chk("int kind", {got.kind, got.save_context}, 3'h3);
        end
        u_seq.clr();
        idle();
    endtask

    task automatic t_map();
        map1(1'b0, 3'h1, 7'h00, 7'h10);
        map1(1'b1, 3'h1, 7'h08, 7'h38);
        map1(1'b0, 3'h1, 7'h0F, 7'h3F);
        map1(1'b0, 3'h2, 7'h00, 7'h16);
        map1(1'b0, 3'h3, 7'h00, 7'h17);
        map1(1'b1, 3'h2, 7'h00, 7'h1E);
        map1(1'b1, 3'h3, 7'h00, 7'h1F);
        map1(1'b1, 3'h1, 7'h06, 7'h16);
        map1(1'b1, 3'h4, 7'h00, 7'h21);
        map1(1'b0, 3'h5, 7'h1D, 7'h1D);
        map1(1'b1, 3'h5, 7'h22, 7'h22);
        map1(1'b0, 3'h5, 7'h7F, 7'h7F);
        map1(1'b0, 3'h5, 7'h20, 7'h00);
        map1(1'b1, 3'h1, 7'h10, 7'h00);
    endtask

    task automatic t_trap();
        lat = 4'h5;
        for (int i = 0; i < 4; i++) begin
            u_seq.post_trap(2'(i));
            grab(4);
            chk("trap ack", acks, 3'h1);
            chk("trap vec", got.vector, 7'h08 + 7'(i));
            idle();
        end
        lat = 4'h0;
    endtask

    task automatic t_prio();
        u_seq.post_int(3'h0, 7'h00);
        u_seq.post_dir();
        u_seq.post_trap(2'h3);
        boundary = '{1'b1, 1'b0};
        grab(4);
        chk("first", acks, 3'h4);
        grab(20);
        chk("direct", {acks, got.kind, got.vector}, {3'h2, 2'h2, 7'h06});
        grab(20);
        chk("third", {acks, got.vector}, {3'h1, 7'h0B});
        idle();
    endtask

    task automatic t_wdog();
        wdog = 1'b1;
        cyc(1);
        wdog = 1'b0;
        chk("wd init", periph_init, 1'b1);
        cyc(1);
        chk("wd fetch", {exc.valid, exc.kind, exc.vector}, {1'b1, 2'h0, 7'h00});
        idle();
        chk("wd blocked", ints_blocked, 1'b1);
        // Trap in the first window must not open interrupts
        u_seq.post_int(3'h0, 7'h00);
        u_seq.post_trap(2'h1);
        grab(4);
        chk("first trap", {acks, got.vector, ints_blocked}, {3'h1, 7'h09, 1'b1});
        idle();
        chk("first trap blocked", {int_ack, ints_blocked}, 2'h1);
        u_seq.clr();
    endtask

    task automatic t_pin();
        pin_n = 1'b0;
        cyc(3);
        chk("pin halt", {cpu_halt, exc.valid}, 2'h2);
        cyc(17);
        rise();
    endtask

    // Main sequence
    initial begin
        {reset, pin_n, wdog, vms, lat, failures, checked} = '0;
        boundary = '0;
        t_reset();
        t_block();
        t_map();
        t_trap();
        t_prio();
        t_wdog();
        t_pin();
        stop_test();
    end

    // Hang guard
    initial begin
        #200us;
        failures++;
        stop_test();
    end
endmodule
